/* hdl/nvc_ctrl.sv */
// bus controller that drives the serial nonvolatile memory
// Functional notes
// - stop: SDA rises while SCL high
// - start: SDA falls while SCL high
// - change SDA only while SCL low
// - ninth clock carries the acknowledge
// - address byte LSB picks read/write
// - write sends two memory address bytes
// - every byte sent MSB first
// - end read: nack then stop/start
// - random read: address write, repeated start
// - start first after a supply dip
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "nvc_defines.svh"
module nvc_ctrl (
   // clock, reset, enable
   input  wire logic              REF_CLK_IN,
   input  wire logic              RST_IN,
   input  wire logic              CE_IN,
   // register port
   input  wire logic [3:0]        ADDR_IN,
   input  wire logic [7:0]        WDATA_IN,
   input  wire logic              WR_IN,
   input  wire logic              RD_IN,
   output logic      [7:0]        RDATA_OUT,
   // link pins
   input  wire logic              SCL_IN,
   input  wire logic              SDA_IN,
   output logic                   SCL_OUT,
   output logic                   SCL_OE_OUT,
   output logic                   SDA_OUT,
   output logic                   SDA_OE_OUT,
   // strap levels to the device, and the sequencer state
   output logic      [2:0]        SEL_OUT,
   output logic                   WP_OUT,
   output nvc_pkg::nvc_state_t    STATE_OUT
);
   import nvc_pkg::*;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   nvc_state_t  state;
   nvc_state_t  next_state;
   nvc_cmd_t    cmd;
   logic [3:0]  cfg;
   logic [7:0]  shreg;
   logic [7:0]  rbyte;
   logic [3:0]  bitn;
   logic [1:0]  phase;
   logic        nack;
   logic        rvalid;
   logic        stop_pend;
   logic        sda_s;
   logic        scl_s;
   logic        tick;
   logic        sda_low;
   logic        scl_low;
   logic        held;

   wire busy       = (state != NVC_IDLE);
   wire wr_ctrl    = WR_IN && (ADDR_IN == `NVC_REG_CTRL) && !busy;
   wire wr_wdata   = WR_IN && (ADDR_IN == `NVC_REG_WDATA);
   wire wr_cfg     = WR_IN && (ADDR_IN == `NVC_REG_CFG);
   wire rd_rdata   = RD_IN && (ADDR_IN == `NVC_REG_RDATA);
   // target byte built from type code, select pins and direction
   wire [7:0] addr_byte = {`NVC_TYPE_CODE, cfg[2:0], WDATA_IN[`NVC_CTRL_READ]};
   wire [7:0] status  = {5'h00, rvalid, nack, busy};
   wire [7:0] rd_mux  = (ADDR_IN == `NVC_REG_STATUS) ? status :
                        (ADDR_IN == `NVC_REG_RDATA)  ? rbyte :
                        (ADDR_IN == `NVC_REG_CFG)    ? {4'h0, cfg} :
                        (ADDR_IN == `NVC_REG_WDATA)  ? cmd.data : 8'h00;
   wire sda_now     = SDA_IN;

   // ----------------------------------------------------------------
   // pin sampling and quarter tick
   // ----------------------------------------------------------------
   nvc_sync u_sda (
      .REF_CLK_IN (REF_CLK_IN),
      .RST_IN     (RST_IN),
      .CE_IN      (CE_IN),
      .D_IN       (sda_now),
      .Q_OUT      (sda_s)
   );
   nvc_sync u_scl (
      .REF_CLK_IN (REF_CLK_IN),
      .RST_IN     (RST_IN),
      .CE_IN      (CE_IN),
      .D_IN       (SCL_IN),
      .Q_OUT      (scl_s)
   );
   nvc_tick u_tick (
      .REF_CLK_IN (REF_CLK_IN),
      .RST_IN     (RST_IN),
      .CE_IN      (CE_IN),
      .RUN_IN     (busy),
      .TICK_OUT   (tick)
   );

   // ----------------------------------------------------------------
   // sequencer: four quarter phases per link clock
   // ----------------------------------------------------------------
   wire last_q   = tick && (phase == 2'd3);
   wire sample_q = tick && (phase == 2'd1);   // SCL high, read the line
   wire byte_end = (bitn == 4'd7);

   // next state on the last quarter of each bit
   always_comb begin
      next_state = state;
      case (state)
         NVC_IDLE:  next_state = state;
         NVC_START: next_state = cmd.wr ? NVC_SEND : (cmd.rd ? NVC_RECV : NVC_STOP);
         NVC_SEND:  next_state = byte_end ? NVC_ACKRX : NVC_SEND;
         NVC_RECV:  next_state = byte_end ? NVC_ACKTX : NVC_RECV;
         NVC_ACKRX: next_state = (nack || stop_pend) ? NVC_STOP : NVC_IDLE;
         NVC_ACKTX: next_state = stop_pend ? NVC_STOP : NVC_IDLE;
         NVC_STOP:  next_state = NVC_IDLE;
         default:   next_state = NVC_IDLE;
      endcase
   end

   // SCL low in phases 0 and 3, high in 1 and 2; SDA moves in phase 0
   // a held bus keeps SCL low between bytes, else the device sees a stray clock
   always_comb begin
      scl_low = (phase == 2'd0) || (phase == 2'd3);
      sda_low = 1'b0;
      case (state)
         NVC_IDLE: begin
            scl_low = held;
            sda_low = 1'b0;
         end
         NVC_START: begin
            // data falls only after the clock has stood high for a quarter
            scl_low = (phase == 2'd3) || (held && (phase == 2'd0));
            sda_low = (phase >= 2'd2);
         end
         NVC_SEND:  sda_low = !shreg[7];
         NVC_RECV:  sda_low = 1'b0;
         NVC_ACKTX: sda_low = cmd.ack;
         NVC_ACKRX: sda_low = 1'b0;
         NVC_STOP: begin
            sda_low = (phase < 2'd2);
            scl_low = (phase == 2'd0);
         end
         default: begin
            scl_low = 1'b0;
            sda_low = 1'b0;
         end
      endcase
   end

   // state, phase and bit counters
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         state <= NVC_IDLE;
         phase <= 2'd0;
         bitn  <= 4'd0;
         held  <= 1'b0;
      end else if (CE_IN) begin
         if (wr_ctrl && (WDATA_IN[`NVC_CTRL_START] || WDATA_IN[`NVC_CTRL_WRITE]
                         || WDATA_IN[`NVC_CTRL_READ] || WDATA_IN[`NVC_CTRL_STOP])) begin
            state <= WDATA_IN[`NVC_CTRL_START] ? NVC_START :
                     WDATA_IN[`NVC_CTRL_WRITE] ? NVC_SEND :
                     WDATA_IN[`NVC_CTRL_READ]  ? NVC_RECV : NVC_STOP;
            phase <= 2'd0;
            bitn  <= 4'd0;
         end else if (tick) begin
            phase <= phase + 2'd1;
            if (last_q) begin
               state <= next_state;
               bitn  <= (state == NVC_SEND || state == NVC_RECV) && !byte_end
                        ? bitn + 4'd1 : 4'd0;
               // the bus stays owned from a start until its stop completes
               if (state == NVC_START) begin
                  held <= 1'b1;
               end else if (state == NVC_STOP) begin
                  held <= 1'b0;
               end
            end
         end
      end
   end

   // command latch: a cmd with ADDRW and START or WRITE sends the target byte, its READ bit giving the direction
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         cmd <= '0;
      end else if (CE_IN) begin
         if (wr_ctrl) begin
            cmd.start <= WDATA_IN[`NVC_CTRL_START];
            cmd.stop  <= WDATA_IN[`NVC_CTRL_STOP];
            cmd.wr    <= WDATA_IN[`NVC_CTRL_WRITE] || WDATA_IN[`NVC_CTRL_ADDRW];
            cmd.rd    <= WDATA_IN[`NVC_CTRL_READ] && !WDATA_IN[`NVC_CTRL_ADDRW];
            cmd.ack   <= WDATA_IN[`NVC_CTRL_ACK];
         end
         if (wr_wdata) begin
            cmd.data <= WDATA_IN;
         end
      end
   end

   // shift register: target byte on an ADDRW cmd, else data; MSB first
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         shreg <= 8'h00;
      end else if (CE_IN) begin
         if (wr_ctrl && WDATA_IN[`NVC_CTRL_ADDRW]) begin
            shreg <= addr_byte;
         end else if (wr_ctrl) begin
            shreg <= cmd.data;
         end else if (sample_q && state == NVC_RECV) begin
            shreg <= {shreg[6:0], sda_s};
         end else if (last_q && state == NVC_SEND) begin
            shreg <= {shreg[6:0], 1'b0};
         end
      end
   end

   // acknowledge result, received byte, stop request
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         nack      <= 1'b0;
         rvalid    <= 1'b0;
         rbyte     <= 8'h00;
         stop_pend <= 1'b0;
      end else if (CE_IN) begin
         if (wr_ctrl) begin
            stop_pend <= WDATA_IN[`NVC_CTRL_STOP];
         end
         if (sample_q && state == NVC_ACKRX) begin
            nack <= sda_s;
         end else if (wr_ctrl) begin
            nack <= 1'b0;
         end
         // a new byte wins over the clearing read
         if (last_q && state == NVC_RECV && byte_end) begin
            rvalid <= 1'b1;
            rbyte  <= shreg;
         end else if (rd_rdata) begin
            rvalid <= 1'b0;
         end
      end
   end

   // configuration: select pin levels and write protect
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         cfg <= `NVC_CFG_RESET;
      end else if (CE_IN && wr_cfg) begin
         cfg <= WDATA_IN[3:0];
      end
   end

   // ----------------------------------------------------------------
   // registered outputs; lines are open drain, enable means pull low
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         SCL_OUT    <= 1'b0;
         SCL_OE_OUT <= 1'b0;
         SDA_OUT    <= 1'b0;
         SDA_OE_OUT <= 1'b0;
         SEL_OUT    <= 3'b000;
         WP_OUT     <= 1'b0;
         RDATA_OUT  <= 8'h00;
         STATE_OUT  <= NVC_IDLE;
      end else if (CE_IN) begin
         SCL_OUT    <= 1'b0;
         SCL_OE_OUT <= scl_low;
         SDA_OUT    <= 1'b0;
         SDA_OE_OUT <= sda_low;
         SEL_OUT    <= cfg[2:0];
         WP_OUT     <= cfg[3];
         RDATA_OUT  <= RD_IN ? rd_mux : 8'h00;
         STATE_OUT  <= state;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // data only moves while the clock is low
   a_sda_steady: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && !SCL_OE_OUT && $past(!SCL_OE_OUT) && busy
       && state != NVC_START && state != NVC_STOP) |-> $stable(SDA_OE_OUT))
      else $error("data line moved while clock high");
   // every sample point finds the clock line really high
   a_scl_high: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && sample_q && busy) |-> scl_s)
      else $error("sampled while clock line low");
   // a held bus keeps its clock low between bytes
   a_idle_hold: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && state == NVC_IDLE && held) |-> ##1 SCL_OE_OUT)
      else $error("clock released between bytes");
   // start: clock already high, then data falls
   a_start_shape: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && state == NVC_START && phase == 2'd1 && tick)
      |=> (!SDA_OE_OUT && !SCL_OE_OUT) ##1 (SDA_OE_OUT && !SCL_OE_OUT))
      else $error("start not pulled low in clock high");
   // stop: data held low under a high clock, then released
   a_stop_rise: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && state == NVC_STOP && phase == 2'd1 && tick)
      |=> (SDA_OE_OUT && !SCL_OE_OUT) ##1 (!SDA_OE_OUT && !SCL_OE_OUT))
      else $error("stop edge not under a high clock");
   // stop ends with the data line released
   a_stop_shape: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (state == NVC_STOP && phase == 2'd3) |-> ##1 !SDA_OE_OUT)
      else $error("stop left data line low");
   // the device's ack slot is left to the device
   a_ack_release: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (state == NVC_ACKRX) |-> ##1 !SDA_OE_OUT)
      else $error("data line held in device ack slot");
   // while the device sends data the line is left alone
   a_recv_release: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (state == NVC_RECV) |-> ##1 !SDA_OE_OUT)
      else $error("data line held while receiving");
   // the ninth clock of every byte is an ack slot
   a_ack_slot: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && last_q && (state == NVC_SEND || state == NVC_RECV) && byte_end)
      |=> (state == NVC_ACKRX || state == NVC_ACKTX))
      else $error("no ack slot after eighth bit");
   // no ack slot before the eighth bit of a sent byte
   a_byte_len: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && last_q && state == NVC_SEND && !byte_end) |=> state == NVC_SEND)
      else $error("byte cut short");
   // first bit on the line is the msb
   a_msb_first: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (state == NVC_SEND && bitn == 4'd0) |-> ##1 (SDA_OE_OUT == !$past(shreg[7])))
      else $error("first bit is not msb");
   // a refused byte is followed by a stop
   a_nack_stop: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && last_q && state == NVC_ACKRX && nack) |=> state == NVC_STOP)
      else $error("no stop after device nack");
   // ack or no-ack as software asked
   a_read_ack: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (state == NVC_ACKTX) |-> ##1 (SDA_OE_OUT == $past(cmd.ack)))
      else $error("read ack slot wrong");
   // target byte carries the type code
   a_target_code: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && wr_ctrl && WDATA_IN[`NVC_CTRL_ADDRW]) |=> shreg[7:4] == `NVC_TYPE_CODE)
      else $error("target code not loaded");
   // direction bit lands in the target byte lsb
   a_read_dir: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (CE_IN && wr_ctrl && WDATA_IN[`NVC_CTRL_ADDRW])
      |=> shreg[0] == $past(WDATA_IN[`NVC_CTRL_READ]))
      else $error("direction bit not loaded");
endmodule

/* shared/nvc_defines.svh */
// constants for the serial memory bus controller
`ifndef NVC_DEFINES_SVH
`define NVC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets of the controller's own command port
// ----------------------------------------------------------------
`define NVC_REG_CTRL      4'h0
`define NVC_REG_ADDR      4'h1
`define NVC_REG_WDATA     4'h2
`define NVC_REG_STATUS    4'h3
`define NVC_REG_RDATA     4'h4
`define NVC_REG_CFG       4'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NVC_CTRL_START    0
`define NVC_CTRL_STOP     1
`define NVC_CTRL_WRITE    2
`define NVC_CTRL_READ     3
`define NVC_CTRL_ACK      4
`define NVC_CTRL_ADDRW    5
`define NVC_ST_BUSY       0
`define NVC_ST_NACK       1
`define NVC_ST_RVALID     2

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define NVC_TYPE_CODE     4'h5
`define NVC_CFG_RESET     4'h0
`define NVC_ADDR_RESET    16'h0000

// ----------------------------------------------------------------
// timing: the link clock is divided from the 50 MHz clock
// ----------------------------------------------------------------
`define NVC_CLK_MHZ       50
`define NVC_SCL_KHZ       400
`define NVC_QTR_CYC       ((`NVC_CLK_MHZ * 1000) / (`NVC_SCL_KHZ * 4))

`endif

/* shared/nvc_pkg.sv */
// types shared by the serial memory bus controller
package nvc_pkg;

   // one-hot bit sequencer states
   typedef enum logic [6:0] {
      NVC_IDLE  = 7'b000_0001,
      NVC_START = 7'b000_0010,
      NVC_SEND  = 7'b000_0100,
      NVC_RECV  = 7'b000_1000,
      NVC_ACKTX = 7'b001_0000,
      NVC_ACKRX = 7'b010_0000,
      NVC_STOP  = 7'b100_0000
   } nvc_state_t;

   // command carried from the register port to the sequencer
   typedef struct packed {
      logic       start;
      logic       stop;
      logic       wr;
      logic       rd;
      logic       ack;
      logic [7:0] data;
   } nvc_cmd_t;

   // open-drain pin as two signals
   typedef struct packed {
      logic o;
      logic oe;
   } nvc_pin_t;

endpackage

/* hdl/nvc_sync.sv */
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module nvc_sync (
   // clock and control
   input  wire logic REF_CLK_IN,
   input  wire logic RST_IN,
   input  wire logic CE_IN,
   // pin in, synchronised level out
   input  wire logic D_IN,
   output logic      Q_OUT
);
   logic meta;

   // first stage feeds only the second stage
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         meta  <= 1'b1;
         Q_OUT <= 1'b1;
      end else if (CE_IN) begin
         meta  <= D_IN;
         Q_OUT <= meta;
      end
   end
endmodule

/* hdl/nvc_tick.sv */
// quarter-period tick divider that paces the link clock
`timescale 1ns/1ps
`include "nvc_defines.svh"
module nvc_tick (
   // clock and control
   input  wire logic REF_CLK_IN,
   input  wire logic RST_IN,
   input  wire logic CE_IN,
   input  wire logic RUN_IN,
   // one-cycle tick
   output logic      TICK_OUT
);
   localparam logic [7:0] QTR = 8'(`NVC_QTR_CYC - 1);
   logic [7:0] cnt;
   wire        at_end = (cnt == QTR);

   // counter restarts whenever the sequencer is idle
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         cnt      <= 8'h00;
         TICK_OUT <= 1'b0;
      end else if (CE_IN) begin
         cnt      <= (!RUN_IN || at_end) ? 8'h00 : cnt + 8'h01;
         TICK_OUT <= RUN_IN && at_end;
      end
   end
endmodule

/* tb/nvc_mem_model.sv */
// behavioural model of the serial byte memory at the far end of the link
`timescale 1ns/1ps
module nvc_mem_model #(
   parameter logic [3:0] TYPE_CODE = 4'h5 // arbitrary value, matches the controller
) (
   // link wires
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   // strap pins
   input  wire logic [2:0] sel_in,
   input  wire logic       wp_in,
   output logic            sda_oe_out
);
   // ----------------------------------------
   // array, latch and bit sequencing
   // ----------------------------------------
   logic [7:0]  mem [32768];
   logic [14:0] adr;
   logic [7:0]  sh;
   logic [2:0]  ph; // 0 idle 1 target 2 high 3 low 4 write 5 read
   logic [3:0]  bitc;
   logic        ack;
   initial begin
      for (int i = 0; i < 32768; i++)
         mem[i] = 8'(i) ^ 8'(i >> 7);
      adr = '0; // no reset pin: latch only cleared by power-up
      ph = '0;
      bitc = '0;
      ack = 1'b0;
      sda_oe_out = 1'b0;
   end
   // start readies for a target byte, stop goes idle
   always @(negedge sda_in) begin
      if (scl_in) begin
         ph = 3'd1;
         bitc = '0;
         sda_oe_out = 1'b0;
      end
   end
   always @(posedge sda_in) begin
      if (scl_in) begin
         ph = 3'd0;
         sda_oe_out = 1'b0;
      end
   end
   // bits taken on the rising clock; in a read the shifter echoes its own bit
   always @(posedge scl_in) begin
      if (ph != 0 && bitc < 8) begin
         sh = {sh[6:0], sda_in};
         bitc = bitc + 4'd1;
         if (bitc == 8) begin
            ack = ph != 5;
            if (ph == 1)
               ack = sh[7:1] == {TYPE_CODE, sel_in};
            if (ph == 2)
               adr[14:8] = sh[6:0];
            if (ph == 3)
               adr[7:0] = sh;
            if (ph == 4)
               ack = !wp_in;
            if (ph == 4 && ack) begin
               mem[adr] = sh;
               adr = adr + 15'd1;
            end
         end
      end else if (ph != 0) begin
         bitc = '0;
         if (ph == 5 ? sda_in : !ack)
            ph = 3'd0;
         else if (ph == 1)
            ph = sh[0] ? 3'd5 : 3'd2;
         else if (ph < 4)
            ph = ph + 3'd1;
         if (ph == 5) begin
            sh = mem[adr];
            adr = adr + 15'd1;
         end
      end
   end
   // the line is only pulled low or released, and only while the clock is low
   always @(negedge scl_in) begin
      if (ph == 5 && bitc < 8)
         sda_oe_out = !sh[7];
      else
         sda_oe_out = bitc == 8 && ph inside {[1:4]} && ack;
   end
endmodule

/* tb/test_nvc_ctrl.sv */
// self-checking bench: controller driving the memory model
`timescale 1ns/1ps
`include "nvc_defines.svh"
module test_nvc_ctrl;
   import nvc_pkg::*;
   // ----------------------------------------
   // stimulus, wires and scoreboard
   // ----------------------------------------
   logic        clk = 0, rst = 1, wr = 0, rd = 0;
   logic [3:0]  addr = '0;
   logic [7:0]  wdata = '0, rdata;
   logic        scl_oe, sda_oe, m_oe, scl_o, sda_o, wp;
   logic [2:0]  sel;
   nvc_state_t  state;
   logic [14:0] cur;
   logic [7:0]  exp_mem [32768];
   int          err_count = 0, comparisons = 0, seed = 32'hf4ef;
   wire         scl = !scl_oe; // pull-ups: a released line reads high
   wire         sda = !(sda_oe || m_oe);
   always #10 clk = !clk;
   nvc_ctrl u_nvc_ctrl (.REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SCL_IN(scl),
      .SDA_IN(sda), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_OUT(sda_o),
      .SDA_OE_OUT(sda_oe), .SEL_OUT(sel), .WP_OUT(wp), .STATE_OUT(state));
   nvc_mem_model #(.TYPE_CODE(`NVC_TYPE_CODE)) u_nvc_mem_model (.scl_in(scl),
      .sda_in(sda), .sel_in(sel), .wp_in(wp), .sda_oe_out(m_oe));
   // comparison, verdict and register port cycles
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (err_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] init_byte(input int i);
      return 8'(i) ^ 8'(i >> 7);
   endfunction
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // one link operation; busy is polled under a bound, long enough for a byte
   task automatic op(input logic [7:0] cmd, input logic nack);
      logic [7:0] s;
      int n;
      reg_wr(`NVC_REG_CTRL, cmd);
      n = 0;
      s = 8'h01;
      while (s[`NVC_ST_BUSY] !== 1'b0 && n < 3000) begin
         reg_rd(`NVC_REG_STATUS, s);
         n++;
      end
      if (n >= 3000)
         err_count++;
      check("nack", 16'(s[`NVC_ST_NACK]), 16'(nack));
   endtask
   task automatic set_addr(input logic [15:0] a);
      op(8'h21, 1'b0);
      reg_wr(`NVC_REG_WDATA, a[15:8]);
      op(8'h04, 1'b0);
      reg_wr(`NVC_REG_WDATA, a[7:0]);
      op(8'h04, 1'b0);
      cur = a[14:0];
   endtask
   task automatic read_n(input int n);
      logic [7:0] d;
      op(8'h29, 1'b0);
      for (int i = 0; i < n; i++) begin
         op(i == n - 1 ? 8'h0A : 8'h18, 1'b0);
         reg_rd(`NVC_REG_RDATA, d);
         check("rdata", 16'(d), 16'(exp_mem[cur]));
         cur = cur + 15'd1;
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0]  d;
      logic [15:0] a;
      logic [2:0]  s;
      for (int i = 0; i < 32768; i++)
         exp_mem[i] = init_byte(i);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("state", 16'(state), 16'(NVC_IDLE));
      check("pins", {12'h0, scl_oe, sda_oe, scl_o, sda_o}, 16'h0000);
      reg_rd(`NVC_REG_CFG, d);
      check("cfg", 16'(d), 16'(`NVC_CFG_RESET));
      reg_rd(4'hF, d);
      check("unmapped", 16'(d), 16'h0000);
      // random select pins, burst write across the top of the array
      s = 3'($random(seed));
      reg_wr(`NVC_REG_CFG, {5'h00, s});
      a = {1'($random(seed)), 15'h7FFE};
      set_addr(a);
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         exp_mem[15'(a + 16'(i))] = d;
         reg_wr(`NVC_REG_WDATA, d);
         op(i == 3 ? 8'h06 : 8'h04, 1'b0);
      end
      check("sel", 16'(sel), 16'(s));
      for (int i = 0; i < 4; i++) begin
         d = u_nvc_mem_model.mem[15'(a + 16'(i))];
         check("mem", 16'(d), 16'(exp_mem[15'(a + 16'(i))]));
      end
      // random read over the wrap, then current address, then a random spot
      set_addr(a);
      read_n(5);
      read_n(2);
      a = 16'($random(seed));
      set_addr(a);
      read_n(3);
      // wrong select bits and wrong type code are refused
      reg_wr(`NVC_REG_WDATA, {`NVC_TYPE_CODE, ~s, 1'b0});
      op(8'h05, 1'b1);
      reg_wr(`NVC_REG_WDATA, {~`NVC_TYPE_CODE, s, 1'b0});
      op(8'h05, 1'b1);
      // protected write: refused, array and latch unchanged
      reg_wr(`NVC_REG_CFG, {4'h0, 1'b1, s});
      // the pin follows the register one clock later
      @(posedge clk);
      #1 check("wp", 16'(wp), 16'h0001);
      set_addr(a);
      reg_wr(`NVC_REG_WDATA, ~exp_mem[a[14:0]]);
      op(8'h06, 1'b1);
      reg_wr(`NVC_REG_CFG, {5'h00, s});
      read_n(1);
      finish_test();
   end
   // hang guard: the sequence needs about 40000 cycles
   initial begin
      #(20 * 90000);
      err_count++;
      finish_test();
   end
endmodule
